// [testbench/mem_ctrl_model.sv]
`timescale 1ns/1ps
module mem_ctrl_model
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic odt_req,
  input wire logic cke_req,
  input wire logic ref_req,
  output logic termination_control_pin,
  output logic cke_pin,
  output logic refresh_cmd_pin
);
  // termination never relied on
  // pins move just after an edge; termination is never read back, it is uncertain in windows
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      termination_control_pin <= 1'b0;
      cke_pin <= 1'b1;
    end
    else
    begin
      termination_control_pin <= odt_req;
      cke_pin <= cke_req;
    end
  end
  // refresh then clock enable
  // one registered cycle per refresh request, seen while clock enable is still high
  always_ff @(posedge aclk)
  begin
    refresh_cmd_pin <= aresetn & ref_req;
  end
endmodule // mem_ctrl_model

// [testbench/odt_powerdown_mode_transition_tb_top.sv]
`timescale 1ns/1ps
module odt_powerdown_mode_transition_tb_top;
  import odt_pd_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0, odt_req = 1'b0, cke_req = 1'b1, ref_req = 1'b0;
  logic odt_pin, cke_pin, ref_pin, termination_resistance, async_mode, window_active;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int mismatches = 0, compares = 0;
  // free running clock, 40 ns
  always #20 aclk = ~aclk;
  mem_ctrl_model ctl (.aclk(aclk), .aresetn(aresetn), .odt_req(odt_req), .cke_req(cke_req),
    .ref_req(ref_req), .termination_control_pin(odt_pin), .cke_pin(cke_pin),
    .refresh_cmd_pin(ref_pin));
  odt_powerdown_mode_transition dut (.aclk(aclk), .aresetn(aresetn),
    .termination_control_pin(odt_pin), .cke_pin(cke_pin), .refresh_cmd_pin(ref_pin),
    .termination_resistance(termination_resistance), .async_mode(async_mode),
    .window_active(window_active), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

  task automatic stop_test();
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  function automatic logic pick(input int s);
    return (s == 0) ? termination_resistance : (s == 1) ? async_mode : window_active;
  endfunction

  // bounded wait on one output; sampled 1 ns after each edge, once updates have landed
  task automatic wait_for(input int s, input logic v, input int lim, output int n);
    n = 0;
    while (pick(s) !== v && n < lim)
    begin
      @(posedge aclk);
      #1;
      n++;
    end
    if (pick(s) !== v)
    begin
      chk("wait_timeout", 32'(s), 32'h0000_FFFF);
      stop_test();
    end
  endtask

  // edges from the request until termination follows; the model's register adds one
  task automatic lat(input logic v, output int n);
    @(posedge aclk);
    odt_req <= v;
    wait_for(0, v, 40, n);
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ta, tw, b;
    int n;
    b = 0;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!b && n < 50)
    begin
      #1;
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      b = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (b) s_axi_bready <= 1'b0;
      n++;
    end
    if (!b)
    begin
      chk("wr_timeout", 32'h0000_0000, 32'h0000_0001);
      stop_test();
    end
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ta, v;
    int n;
    v = 0;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!v && n < 50)
    begin
      #1;
      ta = s_axi_arvalid & s_axi_arready;
      v = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'b0;
      if (v) s_axi_rready <= 1'b0;
      n++;
    end
    if (!v)
    begin
      chk("rd_timeout", 32'h0000_0000, 32'h0000_0001);
      stop_test();
    end
  endtask

  task automatic cke(input logic v);
    @(posedge aclk);
    cke_req <= v;
  endtask

  // dll resync after reset answers asynchronously
  task automatic t_resync();
    int n;
    chk("async_after_reset", {31'h0, async_mode}, 32'h0000_0001);
    lat(1'b1, n);
    chk("async_on", n, 32'h0000_0004);
    lat(1'b0, n);
    chk("async_off", n, 32'h0000_0004);
    wait_for(1, 1'b0, 40, n);
  endtask

  task automatic t_regs();
    logic [31:0] d;
    logic [1:0] r;
    rd(OFS_CTRL, d, r);
    chk("ctrl", d, CTRL_RESET);
    rd(OFS_LAT, d, r);
    chk("lat", d, LAT_RESET);
    rd(OFS_TIMING, d, r);
    chk("timing", d, TIMING_RESET);
    rd(OFS_STATUS, d, r);
    chk("lead", d[15:8], 32'h0000_0004);
    rd(4'h6, d, r);
    chk("unmapped_rresp", r, RESP_SLVERR);
    wr(OFS_STATUS, 32'h0000_FFFF, r);
    chk("status_ro", r, RESP_SLVERR);
  endtask

  // synchronous latency follows write latency; async ignores additive latency
  task automatic t_sync();
    logic [31:0] d;
    logic [1:0] r;
    int n;
    lat(1'b1, n);
    chk("sync_on", n, 32'h0000_0006);
    lat(1'b0, n);
    chk("sync_off", n, 32'h0000_0006);
    wr(OFS_LAT, 32'h0000_0025, r);
    chk("lat_bresp", r, RESP_OKAY);
    rd(OFS_LAT, d, r);
    chk("lat_back", d, 32'h0000_0025);
    chk("lat_rresp", r, RESP_OKAY);
    lat(1'b1, n);
    chk("sync_on_al", n, 32'h0000_0008);
    lat(1'b0, n);
    chk("sync_off_al", n, 32'h0000_0008);
    rd(OFS_STATUS, d, r);
    chk("lead_al", d[15:8], 32'h0000_0006);
    wr(OFS_CTRL, 32'h0000_0002, r);
    #1;
    chk("resync", {31'h0, async_mode}, 32'h0000_0001);
    lat(1'b1, n);
    chk("async_al", n, 32'h0000_0004);
    lat(1'b0, n);
    wait_for(1, 1'b0, 40, n);
    wr(OFS_LAT, LAT_RESET, r);
  endtask

  // dll-off power-down: entry, async inside, exit window then sync again
  task automatic t_pd();
    int n, m;
    cke(1'b0);
    wait_for(2, 1'b1, 10, n);
    chk("pd_async", {31'h0, async_mode}, 32'h0000_0001);
    lat(1'b1, n);
    chk("pd_on", n, 32'h0000_0004);
    lat(1'b0, n);
    chk("pd_off", n, 32'h0000_0004);
    cke(1'b1);
    lat(1'b1, m);
    chk("exit_on", 32'(m >= 4 && m <= 6), 32'h0000_0001);
    wait_for(1, 1'b0, 40, n);
    chk("exit_len", 32'(n + m >= 11 && n + m <= 15), 32'h0000_0001);
    chk("exit_win", {31'h0, window_active}, 32'h0000_0000);
    lat(1'b0, n);
    chk("after_exit", n, 32'h0000_0006);
  endtask

  // dll kept on in power-down: no window, stays synchronous
  task automatic t_dllon();
    logic [1:0] r;
    int n;
    wr(OFS_CTRL, 32'h0000_0001, r);
    cke(1'b0);
    repeat (8) @(posedge aclk);
    #1;
    chk("dllon_win", {30'h0, window_active, async_mode}, 32'h0000_0000);
    lat(1'b1, n);
    chk("dllon_on", n, 32'h0000_0006);
    lat(1'b0, n);
    cke(1'b1);
    wr(OFS_CTRL, CTRL_RESET, r);
  endtask

  // refresh running at clock-enable fall holds off the asynchronous switch
  task automatic t_refresh();
    int n;
    @(posedge aclk);
    ref_req <= 1'b1;
    @(posedge aclk);
    ref_req <= 1'b0;
    cke_req <= 1'b0;
    repeat (6) @(posedge aclk);
    #1;
    chk("ref_hold", {31'h0, async_mode}, 32'h0000_0000);
    wait_for(1, 1'b1, 40, n);
    chk("ref_len", 32'(n >= 10), 32'h0000_0001);
    cke(1'b1);
    wait_for(2, 1'b0, 40, n);
  endtask

  // one-cycle clock-enable low: overlapping windows, either response allowed
  task automatic t_short();
    int n;
    cke(1'b0);
    cke(1'b1);
    lat(1'b1, n);
    chk("short_on", 32'(n >= 4 && n <= 6), 32'h0000_0001);
    lat(1'b0, n);
    chk("short_off", 32'(n >= 4 && n <= 6), 32'h0000_0001);
    wait_for(2, 1'b0, 40, n);
  endtask

  // reset 6 cycles, then the scenarios in turn
  initial
  begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    #1;
    t_resync();
    t_regs();
    t_sync();
    t_pd();
    t_dllon();
    t_refresh();
    t_short();
    stop_test();
  end
endmodule // odt_powerdown_mode_transition_tb_top

// [verilog/odt_pd_pkg.sv]
package odt_pd_pkg;
  // register byte offsets
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_LAT = 4'h4;
  localparam logic [3:0] OFS_TIMING = 4'h8;
  localparam logic [3:0] OFS_STATUS = 4'hC;
  // ctrl fields
  localparam int CTRL_PD_DLL_BIT = 0;
  localparam int CTRL_DLL_RESET_BIT = 1;
  // latency fields
  localparam int LAT_CWL_LSB = 0;
  localparam int LAT_AL_LSB = 4;
  localparam int LAT_FIELD_W = 4;
  // timing fields, in clock cycles
  localparam int TIM_RFC_LSB = 0;
  localparam int TIM_XPDLL_LSB = 8;
  localparam int TIM_FIELD_W = 8;
  // status fields
  localparam int STS_ASYNC_BIT = 0;
  localparam int STS_TERM_BIT = 1;
  localparam int STS_WINDOW_BIT = 2;
  localparam int STS_RESYNC_BIT = 3;
  localparam int STS_LEAD_LSB = 8;
  // reset values
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] LAT_RESET = 32'h0000_0005;
  localparam logic [31:0] TIMING_RESET = 32'h0000_0A1A;
  localparam logic [7:0] RESYNC_CYCLES = 8'h20;
  // clock and asynchronous termination delays, in picoseconds
  localparam int CLK_PERIOD_PS = 40000;
  localparam int ASYNC_TERM_MIN_PS = 2000;
  localparam int ASYNC_TERM_MAX_PS = 8500;
  // least time rounds up, longest rounds down, never below one cycle
  localparam int ASYNC_MIN_RAW = (ASYNC_TERM_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int ASYNC_MAX_RAW = ASYNC_TERM_MAX_PS / CLK_PERIOD_PS;
  localparam int ASYNC_MIN_CYC = (ASYNC_MIN_RAW < 1) ? 1 : ASYNC_MIN_RAW;
  localparam int ASYNC_MAX_CYC = (ASYNC_MAX_RAW < 1) ? 1 : ASYNC_MAX_RAW;
  // synchronous latency and lead time offsets below write latency
  localparam int SYNC_LAT_OFFSET = 2;
  localparam int LEAD_OFFSET = 1;
  // axi response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// [verilog/odt_powerdown_mode_transition.sv]
`timescale 1ns/1ps
module odt_powerdown_mode_transition
  import odt_pd_pkg::*;
#(
  parameter int MAX_LAT = 32
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic termination_control_pin,
  input wire logic cke_pin,
  input wire logic refresh_cmd_pin,
  output logic termination_resistance,
  output logic async_mode,
  output logic window_active,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  localparam int SEL_W = 6;

  initial
  begin
    if (MAX_LAT < 2 || MAX_LAT > (1 << SEL_W))
      $error("odt_powerdown_mode_transition: MAX_LAT out of range");
  end

  logic [31:0] ctrl;
  logic [31:0] lat_reg;
  logic [31:0] timing;
  logic [1:0] odt_meta;
  logic [1:0] cke_meta;
  logic [1:0] ref_meta;
  logic odt_s;
  logic cke_s;
  logic ref_s;
  logic cke_d;
  logic [7:0] refresh_cnt;
  logic [7:0] exit_cnt;
  logic [7:0] resync_cnt;
  logic pd_async;
  logic sync_tap;
  logic [SEL_W-1:0] sync_sel;
  logic [7:0] write_latency;
  logic [7:0] lead_time;
  logic [7:0] sync_lat;
  logic aw_held;
  logic w_held;
  logic [3:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic pd_dll_select_bit;

  assign pd_dll_select_bit = ctrl[CTRL_PD_DLL_BIT];

  // two flops on every pin before any logic looks at it
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      odt_meta <= 2'h0;
      cke_meta <= 2'h3; // idle level of clock enable, no false exit after reset
      ref_meta <= 2'h0;
    end
    else
    begin
      odt_meta <= {odt_meta[0], termination_control_pin};
      cke_meta <= {cke_meta[0], cke_pin};
      ref_meta <= {ref_meta[0], refresh_cmd_pin};
    end
  end

  assign odt_s = odt_meta[1];
  assign cke_s = cke_meta[1];
  assign ref_s = ref_meta[1];

  // latencies from the programmed write latency
  always_comb
  begin
    write_latency = 8'(lat_reg[LAT_CWL_LSB +: LAT_FIELD_W])
                  + 8'(lat_reg[LAT_AL_LSB +: LAT_FIELD_W]);
    sync_lat = (write_latency > 8'(SYNC_LAT_OFFSET)) ?
               write_latency - 8'(SYNC_LAT_OFFSET) : 8'h01;
    lead_time = (write_latency > 8'(LEAD_OFFSET)) ?
                write_latency - 8'(LEAD_OFFSET) : 8'h00;
    // output flop supplies one clock, the tap the rest
    sync_sel = (sync_lat > 8'(MAX_LAT)) ? SEL_W'(MAX_LAT - 1) : SEL_W'(sync_lat - 8'h01);
  end

  // refresh in progress timer, restarted by every refresh command seen while clock enable is high
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      refresh_cnt <= 8'h00;
    else if (ref_s && cke_s)
      refresh_cnt <= timing[TIM_RFC_LSB +: TIM_FIELD_W];
    else if (refresh_cnt != 8'h00)
      refresh_cnt <= refresh_cnt - 8'h01;
  end

  // exit delay timer after clock enable registered high
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cke_d <= 1'b1;
      exit_cnt <= 8'h00;
    end
    else
    begin
      cke_d <= cke_s;
      if (cke_s && !cke_d && !pd_dll_select_bit)
        exit_cnt <= timing[TIM_XPDLL_LSB +: TIM_FIELD_W];
      else if (!cke_s)
        exit_cnt <= 8'h00;
      else if (exit_cnt != 8'h00)
        exit_cnt <= exit_cnt - 8'h01;
    end
  end

  // dll resync period after a software dll reset
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      resync_cnt <= RESYNC_CYCLES;
    else if (s_axi_bvalid && s_axi_bready && aw_addr == OFS_CTRL && w_strb[0]
             && w_data[CTRL_DLL_RESET_BIT])
      resync_cnt <= RESYNC_CYCLES;
    else if (resync_cnt != 8'h00)
      resync_cnt <= resync_cnt - 8'h01;
  end

  // mode choice; windows tolerate either, so switch at the firm edges
  always_comb
  begin
    // dll-off power-down, held sync while refresh runs
    pd_async = !pd_dll_select_bit && !(cke_s && cke_d) && refresh_cnt == 8'h00;
    // exit window keeps async until the dll is back
    // async in dll-off power-down or resync
    async_mode = pd_async || exit_cnt != 8'h00 || resync_cnt != 8'h00;
  end

  // window flag: from clock-enable fall to exit end, dll off only
  assign window_active = !pd_dll_select_bit && (!(cke_s && cke_d) || exit_cnt != 8'h00);

  term_delay_line #(
    .DEPTH(MAX_LAT),
    .SEL_W(SEL_W)
  ) u_delay (
    .aclk(aclk),
    .aresetn(aresetn),
    .din(odt_s),
    .sel(sync_sel),
    .dout(sync_tap)
  );

  // termination output; async path drops pending sync events, allowed in windows
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      termination_resistance <= 1'b0;
    // async: one clock, no additive latency
    else if (async_mode)
      termination_resistance <= odt_s;
    // sync path through the delay line
    else
      termination_resistance <= sync_tap;
  end

  // axi write: address and data taken in either order
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 4'h0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (aw_held && w_held && !s_axi_bvalid)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr == OFS_CTRL || aw_addr == OFS_LAT || aw_addr == OFS_TIMING)
                       ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        aw_held <= 1'b0;
        w_held <= 1'b0;
      end
    end
  end

  // register writes land with the response handshake
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl <= CTRL_RESET;
      lat_reg <= LAT_RESET;
      timing <= TIMING_RESET;
    end
    else if (s_axi_bvalid && s_axi_bready)
    begin
      for (int b = 0; b < 4; b++)
      begin
        if (w_strb[b] && aw_addr == OFS_CTRL)
          ctrl[b*8 +: 8] <= w_data[b*8 +: 8];
        if (w_strb[b] && aw_addr == OFS_LAT)
          lat_reg[b*8 +: 8] <= w_data[b*8 +: 8];
        if (w_strb[b] && aw_addr == OFS_TIMING)
          timing[b*8 +: 8] <= w_data[b*8 +: 8];
      end
      // reset request bit is self clearing
      ctrl[CTRL_DLL_RESET_BIT] <= 1'b0;
    end
  end

  // axi read: one beat, status shows live state
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      unique case (s_axi_araddr)
        OFS_CTRL: s_axi_rdata <= ctrl;
        OFS_LAT: s_axi_rdata <= lat_reg;
        OFS_TIMING: s_axi_rdata <= timing;
        OFS_STATUS:
          s_axi_rdata <= {16'h0000, lead_time, 4'h0, resync_cnt != 8'h00,
                          window_active, termination_resistance, async_mode};
        default:
        begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  a_async_turn_on: assert property (@(posedge aclk) disable iff (!aresetn)
    (async_mode && $rose(odt_s)) |=> termination_resistance)
    else $error("async turn-on missed one-cycle bound");

  a_async_turn_off: assert property (@(posedge aclk) disable iff (!aresetn)
    (async_mode && $fell(odt_s)) |=> !termination_resistance)
    else $error("async turn-off missed one-cycle bound");

  a_async_no_al: assert property (@(posedge aclk) disable iff (!aresetn)
    (async_mode && $past(async_mode) && lat_reg[LAT_AL_LSB +: LAT_FIELD_W] != 4'h0)
      |-> termination_resistance == $past(odt_s))
    else $error("async path delayed by additive latency");

  // no window with dll kept on
  a_window_dll_on: assert property (@(posedge aclk) disable iff (!aresetn)
    (pd_dll_select_bit && resync_cnt == 8'h00 && exit_cnt == 8'h00)
      |-> !window_active && !async_mode)
    else $error("transition window with dll kept on");

  a_refresh_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    (refresh_cnt != 8'h00 && resync_cnt == 8'h00 && exit_cnt == 8'h00) |-> !async_mode)
    else $error("async mode while refresh in progress");

  a_exit_window: assert property (@(posedge aclk) disable iff (!aresetn)
    ($rose(cke_s) && !pd_dll_select_bit && timing[TIM_XPDLL_LSB +: TIM_FIELD_W] > 8'h02)
      |=> (window_active && async_mode) [*2])
    else $error("exit window closed early");

  a_sync_latency: assert property (@(posedge aclk) disable iff (!aresetn)
    (!async_mode && $stable(sync_sel) && sync_sel == 6'(2)) |=> termination_resistance == $past(odt_s, 3))
    else $error("sync latency of three clocks wrong");

  a_resync_async: assert property (@(posedge aclk) disable iff (!aresetn)
    (resync_cnt != 8'h00) |-> async_mode)
    else $error("dll resync not in async mode");

  a_lead_time: assert property (@(posedge aclk) disable iff (!aresetn)
    write_latency > 8'h01 |-> lead_time + 8'h01 == write_latency)
    else $error("lead time not write latency minus one");
endmodule // odt_powerdown_mode_transition

// [verilog/term_delay_line.sv]
`timescale 1ns/1ps
module term_delay_line
  import odt_pd_pkg::*;
#(
  parameter int DEPTH = 32,
  parameter int SEL_W = 6
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic din,
  input wire logic [SEL_W-1:0] sel,
  output logic dout
);
  logic [DEPTH-1:0] stage;

  initial
  begin
    if (DEPTH < 2 || (1 << SEL_W) < DEPTH)
      $error("term_delay_line: depth or select width unusable");
  end

  // one flop per clock of latency
  genvar i;
  generate
    for (i = 0; i < DEPTH; i++)
    begin : g_stage
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
          stage[i] <= 1'b0;
        else if (i == 0)
          stage[i] <= din;
        else
          stage[i] <= stage[(i == 0) ? 0 : i - 1];
      end
    end
  endgenerate

  // tap zero is the undelayed input; caller adds the output flop
  always_comb
  begin
    if (sel == '0)
      dout = din;
    else if (int'(sel) > DEPTH)
      dout = stage[DEPTH-1];
    else
      dout = stage[int'(sel) - 1];
  end

  // delay tap depth; tap two is the default write latency setting
  a_tap_depth: assert property (@(posedge aclk) disable iff (!aresetn)
    (sel == 6'(2) && $stable(sel)) |-> dout == $past(din, 2))
    else $error("delay tap does not match selected depth");
endmodule // term_delay_line
